// [branch_call_move_exec.v]
// Functional notes
// - Reading an upper-page register (operand 5..15) copies it into the working register in one cycle.
// - A long jump loads its 11-bit target into the program counter and takes two cycles.
// - A long call pushes the program counter plus one onto the top of the return stack.
// - A long call then loads its 11-bit target into the program counter, two cycles in all.
// - Storing the working register writes it to file register 0..127 in one cycle.
// - Loading an immediate places the 8-bit operand in the working register in one cycle.
// - A no-operation changes nothing except advancing the program counter by one, in one cycle.
// - Writing an upper-page register (operand 5..15) loads it from the working register in one cycle.
// - A subroutine exit reloads the program counter from the top of the return stack in two cycles.
`timescale 1ns/1ps
`default_nettype none
`include "branch_call_move_defs.vh"
module branch_call_move_exec #(
    parameter STACK_DEPTH = 8,
    parameter SP_W = 3
) (
    input wire core_clk_in,
    input wire rst_n_in,
    input wire op_valid_in,
    input wire [2:0] op_sel_in,
    input wire [10:0] operand_in,
    output wire op_ready_out,
    output reg [10:0] pc_out,
    output reg [7:0] working_register_out,
    output reg [SP_W-1:0] stack_ptr_out,
    output reg file_we_out,
    output reg [6:0] file_addr_out,
    output reg [7:0] file_wdata_out,
    output reg fpage_bad_out
);
    // One-hot states. EXEC takes a new operation; FLUSH is the dead second
    // cycle of a jump, call or exit, in which the prefetched word is dropped.
    localparam ST_EXEC = 2'b01;
    localparam ST_FLUSH = 2'b10;

    // Sequencer state and its next value.
    reg [1:0] state_r;
    reg [1:0] state_nxt;

    // Next values of the architectural registers and strobes.
    reg [10:0] pc_nxt;
    reg [7:0] wreg_nxt;
    reg [SP_W-1:0] sp_nxt;
    reg file_we_nxt;
    reg [6:0] file_addr_nxt;
    reg [7:0] file_wdata_nxt;
    reg fpage_bad_nxt;

    // Write enables of the two internal memories.
    reg stack_push_nxt;
    reg fpage_write_nxt;

    // Storage has no reset so it maps onto plain memory; reading a slot
    // before it was written returns an unknown value.
    reg [7:0] fpage_mem [0:`FPAGE_COUNT-1];
    reg [10:0] stack_mem [0:STACK_DEPTH-1];

    wire [3:0] fsel;
    wire fsel_ok;
    wire take;
    wire [SP_W-1:0] sp_up;
    wire [SP_W-1:0] sp_down;
    wire [10:0] stack_top;

    // Advance the program counter by one; it wraps at the top of its space.
    function [10:0] pc_step;
        input [10:0] pc;
        begin
            pc_step = pc + `PC_STEP;
        end
    endfunction

    // True when a select value names an implemented upper-page register.
    function fpage_in_range;
        input [3:0] sel;
        begin
            fpage_in_range = (sel >= `FPAGE_LOW) && (sel <= `FPAGE_HIGH);
        end
    endfunction

    // Move the stack pointer one level; over- and underflow wrap silently,
    // so software must keep calls and exits paired.
    // SP_W must be the base-two log of STACK_DEPTH so that wrap and depth agree.
    function [SP_W-1:0] sp_move;
        input [SP_W-1:0] sp;
        input up;
        begin
            if (up) begin
                sp_move = sp + {{(SP_W-1){1'b0}}, 1'b1};
            end else begin
                sp_move = sp - {{(SP_W-1){1'b0}}, 1'b1};
            end
        end
    endfunction

    // The operand's low nibble selects the upper-page register.
    assign fsel = operand_in[`FSEL_MSB:0];
    assign fsel_ok = fpage_in_range(fsel);

    // Ready is low only in the flush cycle; an offer made then is ignored,
    // which is cheaper than queueing it behind the branch.
    assign op_ready_out = state_r[0];
    assign take = op_valid_in && op_ready_out;

    // The stack pointer names the next free slot, so the top is one below it.
    assign sp_up = sp_move(stack_ptr_out, 1'b1);
    assign sp_down = sp_move(stack_ptr_out, 1'b0);
    assign stack_top = stack_mem[sp_down];

    // Decode of the offered operation into next values. Every output of this
    // process starts from its held value, or low for the strobes, so no path leaves a latch behind.
    always @* begin
        state_nxt = state_r;
        pc_nxt = pc_out;
        wreg_nxt = working_register_out;
        sp_nxt = stack_ptr_out;
        file_we_nxt = 1'b0;
        file_addr_nxt = file_addr_out;
        file_wdata_nxt = file_wdata_out;
        fpage_bad_nxt = 1'b0;
        stack_push_nxt = 1'b0;
        fpage_write_nxt = 1'b0;

        case (state_r)
            ST_EXEC: begin
                if (take) begin
                    // Every accepted operation moves the counter on; branches override it.
                    pc_nxt = pc_step(pc_out);
                    case (op_sel_in)
                        `OP_NOP: begin
                        end
                        `OP_READ_FPAGE: begin
                            if (fsel_ok) begin
                                wreg_nxt = fpage_mem[fsel];
                            end else begin
                                fpage_bad_nxt = 1'b1;
                            end
                        end
                        `OP_WRITE_FPAGE: begin
                            if (fsel_ok) begin
                                fpage_write_nxt = 1'b1;
                            end else begin
                                fpage_bad_nxt = 1'b1;
                            end
                        end
                        `OP_LONG_JUMP: begin
                            pc_nxt = operand_in;
                            state_nxt = ST_FLUSH;
                        end
                        `OP_LONG_CALL: begin
                            stack_push_nxt = 1'b1;
                            sp_nxt = sp_up;
                            pc_nxt = operand_in;
                            state_nxt = ST_FLUSH;
                        end
                        `OP_STORE_WORKING: begin
                            file_we_nxt = 1'b1;
                            file_addr_nxt = operand_in[`FADDR_MSB:0];
                            file_wdata_nxt = working_register_out;
                        end
                        `OP_LOAD_IMM: begin
                            wreg_nxt = operand_in[`IMM_MSB:0];
                        end
                        `OP_SUB_EXIT: begin
                            // An empty stack wraps, like the hardware stack it models.
                            pc_nxt = stack_top;
                            sp_nxt = sp_down;
                            state_nxt = ST_FLUSH;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_FLUSH: begin
                // The offer seen in this cycle leaves no trace.
                state_nxt = ST_EXEC;
            end
            default: begin
                state_nxt = ST_EXEC;
            end
        endcase
    end

    // Architectural registers. The file strobes are one-cycle pulses because
    // their next value defaults to low in the decode above.
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= ST_EXEC;
            pc_out <= `PC_RESET;
            working_register_out <= `WREG_RESET;
            stack_ptr_out <= `SP_RESET;
            file_we_out <= 1'b0;
            file_addr_out <= `FILE_ADDR_RESET;
            file_wdata_out <= `FILE_WDATA_RESET;
            fpage_bad_out <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pc_out <= pc_nxt;
            working_register_out <= wreg_nxt;
            stack_ptr_out <= sp_nxt;
            file_we_out <= file_we_nxt;
            file_addr_out <= file_addr_nxt;
            file_wdata_out <= file_wdata_nxt;
            fpage_bad_out <= fpage_bad_nxt;
        end
    end

    // The memories are written from the same decode as the registers, so a
    // call pushes its return address at the edge that loads the target.
    always @(posedge core_clk_in) begin
        if (stack_push_nxt) begin
            stack_mem[stack_ptr_out] <= pc_step(pc_out);
        end
        if (fpage_write_nxt) begin
            fpage_mem[fsel] <= working_register_out;
        end
    end

endmodule // branch_call_move_exec
`default_nettype wire

// [branch_call_move_defs.vh]
`ifndef BRANCH_CALL_MOVE_DEFS_VH
`define BRANCH_CALL_MOVE_DEFS_VH
// Operation select codes presented on op_sel_in.
`define OP_NOP 3'h0
`define OP_READ_FPAGE 3'h1
`define OP_WRITE_FPAGE 3'h2
`define OP_LONG_JUMP 3'h3
`define OP_LONG_CALL 3'h4
`define OP_STORE_WORKING 3'h5
`define OP_LOAD_IMM 3'h6
`define OP_SUB_EXIT 3'h7
// Upper-page register window.
`define FPAGE_LOW 4'h5
`define FPAGE_HIGH 4'hf
`define FPAGE_COUNT 16
`define PC_RESET 11'h000
`define WREG_RESET 8'h00
`define SP_RESET 3'h0
`define FILE_ADDR_RESET 7'h00
`define FILE_WDATA_RESET 8'h00
// Program counter step and operand field limits.
`define PC_STEP 11'h001
`define FSEL_MSB 3
`define FADDR_MSB 6
`define IMM_MSB 7
`endif

// [exec_checker_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module exec_checker #(parameter SP_W = 3) (
    input wire core_clk_in, rst_n_in, op_valid_in, op_ready_out, file_we_out, fpage_bad_out,
    input wire [2:0] op_sel_in,
    input wire [10:0] operand_in, pc_out,
    input wire [7:0] working_register_out, file_wdata_out,
    input wire [6:0] file_addr_out,
    input wire [SP_W-1:0] stack_ptr_out);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // One-hot of the operation taken at this edge keeps each antecedent short.
    wire [7:0] g = {8{op_valid_in & op_ready_out}} & (8'h01 << op_sel_in);
    wire [10:0] o = operand_in, pc = pc_out;
    wire [7:0] w = working_register_out;
    wire [SP_W-1:0] sp = stack_ptr_out;
    property p_jmp; g[3] |=> pc == $past(o) && !op_ready_out ##1 op_ready_out; endproperty
    a_jmp: assert property (p_jmp) else $error("jump");
    property p_call; g[4] |=> pc == $past(o) && sp == SP_W'($past(sp) + 1); endproperty
    a_call: assert property (p_call) else $error("call");
    property p_ret; g[7] |=> sp == SP_W'($past(sp) - 1) && !op_ready_out; endproperty
    a_ret: assert property (p_ret) else $error("exit");
    property p_st;
        g[5] |=> file_we_out && file_addr_out == $past(o[6:0]) && file_wdata_out == $past(w);
    endproperty
    a_st: assert property (p_st) else $error("store");
    property p_ld; g[6] |=> w == $past(o[7:0]) && pc == $past(pc) + 11'h001; endproperty
    a_ld: assert property (p_ld) else $error("load");
    property p_nop; g[0] |=> pc == $past(pc) + 11'h001 && $stable(w) && $stable(sp); endproperty
    a_nop: assert property (p_nop) else $error("nop");
    property p_bad; g[1] | g[2] |=> fpage_bad_out == ($past(o[3:0]) < 4'h5); endproperty
    a_bad: assert property (p_bad) else $error("fpage");
    property p_wr; g[2] |=> $stable(w) && !file_we_out; endproperty
    a_wr: assert property (p_wr) else $error("fwrite");
    cover property (g[4]);
    cover property (g[7]);
    cover property (g[5]);
endmodule // exec_checker
bind branch_call_move_exec exec_checker #(.SP_W(SP_W)) u_exec_checker (.*);
`default_nettype wire

// [tb_branch_call_move_exec.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_branch_call_move_exec;
    logic core_clk_in = 0, rst_n_in = 0, op_valid_in = 0, op_ready_out, file_we_out, fpage_bad_out;
    logic [2:0] op_sel_in = 0, stack_ptr_out, sp = 0, rs;
    logic [10:0] operand_in = 0, pc_out, pc = 0, ro, stk [8];
    logic [7:0] working_register_out, file_wdata_out, w = 0, fp [16];
    logic [6:0] file_addr_out;
    integer failures = 0, tests_run = 0, seed = 32'ha559, d = 0;
    branch_call_move_exec u_branch_call_move_exec (.*);
    initial forever #2.5 core_clk_in = ~core_clk_in;
    initial begin
        #20000 failures++;
        stop_test;
    end
    task stop_test;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [21:0] g, e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task op(input logic [2:0] s, input logic [10:0] a);
        logic b, l;
        b = (s == 1 || s == 2) && a < 5;
        l = s == 3 || s == 4 || s == 7;
        op_valid_in = 1;
        op_sel_in = s;
        operand_in = a;
        @(negedge core_clk_in);
        if (s == 5) chk({file_wdata_out, file_addr_out}, {w, a[6:0]});
        if (s == 1 && !b) w = fp[a];
        if (s == 2 && !b) fp[a] = w;
        if (s == 6) w = a[7:0];
        if (s == 4) stk[sp] = pc + 1;
        sp = sp + (s == 4) - (s == 7);
        pc = s == 7 ? stk[sp] : l ? a : pc + 1;
        chk({file_we_out, fpage_bad_out, op_ready_out}, {s == 5, b, !l});
        chk({pc_out, working_register_out, stack_ptr_out}, {pc, w, sp});
        // The offer made while the core is busy must leave no trace.
        if (l) begin
            op_sel_in = 6;
            @(negedge core_clk_in);
        end
    endtask
    initial begin
        repeat (20) @(negedge core_clk_in);
        rst_n_in = 1;
        for (int i = 4; i < 16; i++) begin
            op(6, $random(seed));
            op(2, i);
            op(1, i);
        end
        op(5, 127);
        op(4, 2047);
        op(7, 0);
        repeat (400) begin
            rs = $random(seed);
            ro = $random(seed);
            if (rs == 7 && d == 0) rs = 0;
            d = d + (rs == 4) - (rs == 7);
            op(rs, rs == 1 || rs == 2 ? ro[3:0] : ro);
        end
        stop_test;
    end
endmodule // tb_branch_call_move_exec
`default_nettype wire
